// ### common/loop_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the loopback controller.
`ifndef LOOP_CTRL_MAP_SVH
`define LOOP_CTRL_MAP_SVH
`define LOOP_CTRL_INDEX 8'h05
`define LOOP_CTRL_ADDR 8'h14
`define LOOP_STATUS_ADDR 8'h18
`define LOOP_MASK_ADDR 8'h1C
`define LOOP_PATTERN_ADDR 8'h20
`define LOOP_CTRL_RESET 8'h00
`define LOOP_MASK_RESET 8'h00
`define LOOP_PATTERN_RESET 32'h00000000
`define FLD_LOCAL_LOOP 7
`define FLD_REMOTE_LOOP 6
`define FLD_AUTO_ENABLE 5
`define FLD_ANALOG_LOOP 4
`define FLD_JITTER_BYPASS 3
`define FLD_ERR_SEL_HI 2
`define FLD_ERR_SEL_LO 0
`define STS_LOOP_UP 0
`define STS_LOOP_DOWN 1
`define STS_REMOTE_ACTIVE 2
`define QUAL_TIME_S 5
`define CLOCK_HZ 125000000
`define QUAL_CYCLES (`QUAL_TIME_S * `CLOCK_HZ)
`endif

// ### common/loop_ctrl_pkg.sv
// Types shared by the loopback controller modules.
package loop_ctrl_pkg;
	typedef enum logic [1:0] {AUTO_IDLE, AUTO_LOOPED} auto_state_type;
	typedef logic [7:0] ctrl_byte_type;
endpackage : loop_ctrl_pkg

// ### hdl/qual_timer.sv
// Qualification timer that reports a detect level held for a full interval.
`timescale 1ns/1ps
module qual_timer #(
	parameter int unsigned CYCLES = 625000000
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic detect,
	output logic qualified
);
	logic [31:0] count_q;

	// Any drop of the detect level restarts the interval from zero.
	always_ff @(posedge aclk) begin
		if (!aresetn || clear || !detect) begin
			count_q <= 32'h00000000;
		end else if (count_q < CYCLES) begin
			count_q <= count_q + 32'h00000001;
		end
	end

	assign qualified = detect && (count_q >= CYCLES - 1);

	restart_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!detect |=> count_q == 32'h00000000) else $error("timer did not restart on drop");
endmodule : qual_timer

// ### hdl/loop_pattern_match.sv
// Loop code matcher that compares the newest received bits with a programmed pattern.
`timescale 1ns/1ps
module loop_pattern_match #(
	parameter int unsigned LEN = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic bit_valid,
	input wire logic bit_in,
	input wire logic [LEN-1:0] pattern,
	output logic seen
);
	logic [LEN-1:0] shift_q;
	logic [LEN-1:0] fill_q;

	// Matching waits until a full pattern length has been shifted in, so reset zeros never match.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= '0;
			fill_q <= '0;
		end else if (bit_valid) begin
			shift_q <= {shift_q[LEN-2:0], bit_in};
			fill_q <= {fill_q[LEN-2:0], 1'b1};
		end
	end

	// The seen level stands while the programmed pattern is being received.
	assign seen = (&fill_q) && (shift_q == pattern);
endmodule : loop_pattern_match

// ### hdl/loop_ctrl.sv
// Loopback path selection and automatic remote loop control behind an AXI4-Lite slave.
`timescale 1ns/1ps
`include "loop_ctrl_map.svh"

module loop_ctrl #(
	parameter int unsigned QUAL_CYCLES = `QUAL_CYCLES,
	parameter int unsigned CODE_LEN = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sys_tx_positive,
	input wire logic sys_tx_negative,
	input wire logic rec_rx_positive,
	input wire logic rec_rx_negative,
	input wire logic rec_rx_clock,
	input wire logic jit_rx_positive,
	input wire logic jit_rx_negative,
	input wire logic jit_rx_clock,
	input wire logic line_rx_a,
	input wire logic line_rx_b,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	output logic line_tx_a,
	output logic line_tx_b,
	output logic front_rx_a,
	output logic front_rx_b,
	output logic jit_in_positive,
	output logic jit_in_negative,
	output logic tx_path_positive,
	output logic tx_path_negative,
	output logic rx_out_positive,
	output logic rx_out_negative,
	output logic rx_out_clock,
	output logic backplane_from_jitter,
	output logic [2:0] error_count_select,
	output logic loop_up_seen,
	output logic loop_down_seen,
	output logic remote_loop_active,
	output logic irq
);
	loop_ctrl_pkg::ctrl_byte_type ctrl_q;
	loop_ctrl_pkg::ctrl_byte_type mask_q;
	loop_ctrl_pkg::auto_state_type auto_q;
	logic [31:0] pattern_q;
	logic [2:0] status_q;
	logic [2:0] event_set;
	logic aw_held_q;
	logic w_held_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic do_write;
	logic do_read;
	logic status_read;
	logic auto_enable_fall;
	logic up_seen_q;
	logic down_seen_q;
	logic up_qualified;
	logic down_qualified;
	logic remote_loop;
	logic tx_pos_q;
	logic tx_neg_q;
	logic enable_q;

	// Write address and data are caught independently, so the master may offer them in any order.
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_q <= 1'b0;
			end
		end
	end

	// The write response follows the register update; unmapped addresses answer with a slave error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_q == `LOOP_CTRL_ADDR || aw_addr_q == `LOOP_MASK_ADDR ||
				aw_addr_q == `LOOP_PATTERN_ADDR || aw_addr_q == `LOOP_STATUS_ADDR) ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control, mask and pattern registers; only byte lanes with a strobe are written.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `LOOP_CTRL_RESET;
			mask_q <= `LOOP_MASK_RESET;
			pattern_q <= `LOOP_PATTERN_RESET;
		end else if (do_write) begin
			if (aw_addr_q == `LOOP_CTRL_ADDR && w_strb_q[0]) begin
				ctrl_q <= w_data_q[7:0];
			end
			if (aw_addr_q == `LOOP_MASK_ADDR && w_strb_q[0]) begin
				mask_q <= w_data_q[7:0];
			end
			if (aw_addr_q == `LOOP_PATTERN_ADDR) begin
				for (int i = 0; i < 4; i++) begin
					if (w_strb_q[i]) begin
						pattern_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
					end
				end
			end
		end
	end

	// Read channel: one read at a time, data registered, status cleared by its own read.
	assign s_axi_arready = !s_axi_rvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign status_read = do_read && s_axi_araddr == `LOOP_STATUS_ADDR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (do_read) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			unique case (s_axi_araddr)
				`LOOP_CTRL_ADDR: s_axi_rdata <= {24'h000000, ctrl_q};
				`LOOP_MASK_ADDR: s_axi_rdata <= {24'h000000, mask_q};
				`LOOP_PATTERN_ADDR: s_axi_rdata <= pattern_q;
				`LOOP_STATUS_ADDR: s_axi_rdata <= {29'h00000000, status_q};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Pattern matchers for the loop-up code (low half) and loop-down code (high half).
	loop_pattern_match #(.LEN(CODE_LEN)) up_match (
		.aclk(aclk),
		.aresetn(aresetn),
		.bit_valid(rx_bit_valid),
		.bit_in(rx_bit),
		.pattern(pattern_q[15:0]),
		.seen(loop_up_seen)
	);

	loop_pattern_match #(.LEN(CODE_LEN)) down_match (
		.aclk(aclk),
		.aresetn(aresetn),
		.bit_valid(rx_bit_valid),
		.bit_in(rx_bit),
		.pattern(pattern_q[31:16]),
		.seen(loop_down_seen)
	);

	// Falling edge of the auto enable bit, taken from the register itself.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_q <= 1'b0;
		end else begin
			enable_q <= ctrl_q[`FLD_AUTO_ENABLE];
		end
	end
	assign auto_enable_fall = enable_q && !ctrl_q[`FLD_AUTO_ENABLE];

	// Each timer only runs in the state where its code matters.
	qual_timer #(.CYCLES(QUAL_CYCLES)) up_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(auto_enable_fall || auto_q != loop_ctrl_pkg::AUTO_IDLE),
		.detect(loop_up_seen && ctrl_q[`FLD_AUTO_ENABLE]),
		.qualified(up_qualified)
	);

	qual_timer #(.CYCLES(QUAL_CYCLES)) down_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(auto_enable_fall || auto_q != loop_ctrl_pkg::AUTO_LOOPED),
		.detect(loop_down_seen),
		.qualified(down_qualified)
	);

	// Automatic remote loop state; the looped state is the remote-loop-active status level.
	always_ff @(posedge aclk) begin
		if (!aresetn || auto_enable_fall) begin
			auto_q <= loop_ctrl_pkg::AUTO_IDLE;
		end else begin
			unique case (auto_q)
				loop_ctrl_pkg::AUTO_IDLE: begin
					if (ctrl_q[`FLD_AUTO_ENABLE] && up_qualified) begin
						auto_q <= loop_ctrl_pkg::AUTO_LOOPED;
					end
				end
				loop_ctrl_pkg::AUTO_LOOPED: begin
					if (down_qualified) begin
						auto_q <= loop_ctrl_pkg::AUTO_IDLE;
					end
				end
			endcase
		end
	end
	assign remote_loop_active = auto_q == loop_ctrl_pkg::AUTO_LOOPED;
	assign remote_loop = ctrl_q[`FLD_REMOTE_LOOP] || remote_loop_active;

	// Sticky events: rising loop-up, rising loop-down, entry into remote loop (exit sets nothing).
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_seen_q <= 1'b0;
			down_seen_q <= 1'b0;
		end else begin
			up_seen_q <= loop_up_seen;
			down_seen_q <= loop_down_seen;
		end
	end
	assign event_set[`STS_LOOP_UP] = loop_up_seen && !up_seen_q;
	assign event_set[`STS_LOOP_DOWN] = loop_down_seen && !down_seen_q;
	assign event_set[`STS_REMOTE_ACTIVE] = (auto_q == loop_ctrl_pkg::AUTO_IDLE) && up_qualified &&
		ctrl_q[`FLD_AUTO_ENABLE] && !auto_enable_fall;

	// A set in the same cycle as the clearing read wins, so no event is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= 3'h0;
		end else begin
			status_q <= (status_read ? 3'h0 : status_q) | event_set;
		end
	end
	assign irq = |(status_q & mask_q[2:0]);

	// Data path steering, registered so all data outputs come from flip-flops.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_pos_q <= 1'b0;
			tx_neg_q <= 1'b0;
			jit_in_positive <= 1'b0;
			jit_in_negative <= 1'b0;
			rx_out_positive <= 1'b0;
			rx_out_negative <= 1'b0;
			rx_out_clock <= 1'b0;
			front_rx_a <= 1'b0;
			front_rx_b <= 1'b0;
		end else begin
			// Remote loop takes recovered data and ignores the system transmit inputs.
			tx_pos_q <= remote_loop ? rec_rx_positive : sys_tx_positive;
			tx_neg_q <= remote_loop ? rec_rx_negative : sys_tx_negative;
			// The attenuator input follows the path that is looped, in the receive direction otherwise.
			jit_in_positive <= ctrl_q[`FLD_LOCAL_LOOP] ? sys_tx_positive : rec_rx_positive;
			jit_in_negative <= ctrl_q[`FLD_LOCAL_LOOP] ? sys_tx_negative : rec_rx_negative;
			// Bypass hands the recovered signals straight out; local loop still goes via the attenuator.
			if (ctrl_q[`FLD_JITTER_BYPASS] && !ctrl_q[`FLD_LOCAL_LOOP]) begin
				rx_out_positive <= rec_rx_positive;
				rx_out_negative <= rec_rx_negative;
				rx_out_clock <= rec_rx_clock;
			end else begin
				rx_out_positive <= jit_rx_positive;
				rx_out_negative <= jit_rx_negative;
				rx_out_clock <= jit_rx_clock;
			end
			// Analog loop feeds the receiver from its own transmit drive and drops the line.
			front_rx_a <= ctrl_q[`FLD_ANALOG_LOOP] ? tx_pos_q : line_rx_a;
			front_rx_b <= ctrl_q[`FLD_ANALOG_LOOP] ? tx_neg_q : line_rx_b;
		end
	end

	// Line transmit always follows the transmit path register, which carries recovered data in remote loop.
	assign line_tx_a = tx_pos_q;
	assign line_tx_b = tx_neg_q;
	assign tx_path_positive = tx_pos_q;
	assign tx_path_negative = tx_neg_q;
	assign backplane_from_jitter = 1'b1;
	assign error_count_select = ctrl_q[`FLD_ERR_SEL_HI:`FLD_ERR_SEL_LO];

	sequence looped_now_s;
		auto_q == loop_ctrl_pkg::AUTO_LOOPED;
	endsequence
	sequence enable_dropped_s;
		auto_enable_fall;
	endsequence

	auto_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
		enable_dropped_s |=> !remote_loop_active) else $error("auto loop not reset by enable fall");
	enter_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!remote_loop_active && up_qualified && ctrl_q[`FLD_AUTO_ENABLE] && !auto_enable_fall)
		|=> looped_now_s) else $error("loop-up did not enter remote loop");
	leave_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(looped_now_s and down_qualified) |=> !remote_loop_active) else $error("loop-down did not exit");
	remote_or_a: assert property (@(posedge aclk) disable iff (!aresetn)
		remote_loop_active |=> ##0 (tx_pos_q == $past(rec_rx_positive))) else $error("remote loop ignored");
	manual_remote_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_q[`FLD_REMOTE_LOOP] && $stable(ctrl_q)) |=> tx_neg_q == $past(rec_rx_negative))
		else $error("manual remote loop ignored");
	analog_feed_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q[`FLD_ANALOG_LOOP] |=> front_rx_a == $past(tx_pos_q)) else $error("analog loop not fed");
	local_feed_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q[`FLD_LOCAL_LOOP] |=> jit_in_positive == $past(sys_tx_positive)) else $error("local loop lost");
	bypass_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_q[`FLD_JITTER_BYPASS] && !ctrl_q[`FLD_LOCAL_LOOP]) |=> rx_out_clock == $past(rec_rx_clock))
		else $error("bypass not taken");
	// The select lines must follow the low bits of the word written to the control register.
	err_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && aw_addr_q == `LOOP_CTRL_ADDR && w_strb_q[0]) |=> error_count_select == $past(w_data_q[2:0]))
		else $error("error select mismatch");
	// A match can only begin on a newly shifted bit that agrees with the pattern's newest bit.
	up_seen_a: assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(loop_up_seen) && $stable(pattern_q)) |-> $past(rx_bit_valid) && $past(rx_bit) == pattern_q[0])
		else $error("loop-up seen wrong");
endmodule : loop_ctrl

// ### tb/line_side_model.sv
// Behavioural line and framer side that feeds the loopback controller.
`timescale 1ns/1ps
module line_side_model (
	input wire logic aclk,
	input wire logic send_en,
	input wire logic send_level,
	output logic sys_tx_positive,
	output logic sys_tx_negative,
	output logic rec_rx_positive,
	output logic rec_rx_negative,
	output logic rec_rx_clock,
	output logic jit_rx_positive,
	output logic jit_rx_negative,
	output logic jit_rx_clock,
	output logic line_rx_a,
	output logic line_rx_b,
	output logic rx_bit_valid,
	output logic rx_bit
);
	logic idle_q = 1'b0;
	// Each source holds its own level so that every route can be told apart at the outputs.
	assign sys_tx_positive = 1'b1;
	assign sys_tx_negative = 1'b0;
	assign rec_rx_positive = 1'b0;
	assign rec_rx_negative = 1'b1;
	assign rec_rx_clock = 1'b0;
	assign jit_rx_positive = 1'b1;
	assign jit_rx_negative = 1'b0;
	assign jit_rx_clock = 1'b1;
	assign line_rx_a = 1'b0;
	assign line_rx_b = 1'b1;
	// Outside a code burst the bit line toggles, so a stale level can never pass for a code.
	always @(posedge aclk) begin
		idle_q <= ~idle_q;
	end
	assign rx_bit_valid = send_en;
	assign rx_bit = send_en ? send_level : idle_q;
endmodule : line_side_model

// ### tb/loop_ctrl_tb.sv
// Self-checking testbench of the loopback controller driven over its register bus.
`timescale 1ns/1ps
`include "loop_ctrl_map.svh"
module loop_ctrl_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic send_en = 1'b0, send_level = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic stp, stn, rrp, rrn, rrc, jrp, jrn, jrc, lra, lrb, bv, bt;
	logic lta, ltb, fra, frb, jip, jin, tpp, tpn, rop, ron, roc, bpj, lus, lds, act, irq;
	logic [2:0] ecs;
	logic [7:0] route_ctrl [5] = '{8'h00, 8'h80, 8'h40, 8'h10, 8'h08};
	logic [10:0] route_exp [5] = '{11'h34D, 11'h54D, 11'h2AD, 11'h355, 11'h34A};
	int bad_count = 0;
	int checks_done = 0;
	int i;

	// The clock toggles every half period of 4 ns.
	always #4 aclk = ~aclk;

	loop_ctrl #(.QUAL_CYCLES(20), .CODE_LEN(16)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sys_tx_positive(stp), .sys_tx_negative(stn), .rec_rx_positive(rrp),
		.rec_rx_negative(rrn), .rec_rx_clock(rrc), .jit_rx_positive(jrp), .jit_rx_negative(jrn),
		.jit_rx_clock(jrc), .line_rx_a(lra), .line_rx_b(lrb), .rx_bit_valid(bv), .rx_bit(bt),
		.line_tx_a(lta), .line_tx_b(ltb), .front_rx_a(fra), .front_rx_b(frb), .jit_in_positive(jip),
		.jit_in_negative(jin), .tx_path_positive(tpp), .tx_path_negative(tpn), .rx_out_positive(rop),
		.rx_out_negative(ron), .rx_out_clock(roc), .backplane_from_jitter(bpj), .error_count_select(ecs),
		.loop_up_seen(lus), .loop_down_seen(lds), .remote_loop_active(act), .irq(irq));

	line_side_model partner (.aclk(aclk), .send_en(send_en), .send_level(send_level),
		.sys_tx_positive(stp), .sys_tx_negative(stn), .rec_rx_positive(rrp), .rec_rx_negative(rrn),
		.rec_rx_clock(rrc), .jit_rx_positive(jrp), .jit_rx_negative(jrn), .jit_rx_clock(jrc),
		.line_rx_a(lra), .line_rx_b(lrb), .rx_bit_valid(bv), .rx_bit(bt));

	// Every comparison is counted; a mismatch is reported at once so one run shows all faults.
	task automatic check_bit(input logic got, input logic exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check_bit

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check_word

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up

	task automatic give_up();
		bad_count++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		wrap_up();
	endtask : give_up

	// Ready is looked at on the falling edge, so the release lands right after the taking edge.
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		logic pa, pw, pb, ta, tw, tb;
		int n;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && (pa || pw || pb); n++) begin
			@(negedge aclk);
			ta = pa && awready;
			tw = pw && wready;
			tb = pb && bvalid;
			if (tb) rs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
			pb = pb && !tb;
		end
		if (pa || pw || pb) give_up();
		@(negedge aclk);
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a);
		logic pa, pr, ta, tr;
		int n;
		pa = 1'b1;
		pr = 1'b1;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && (pa || pr); n++) begin
			@(negedge aclk);
			ta = pa && arready;
			tr = pr && rvalid;
			if (tr) rd = rdata;
			if (tr) rs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			pa = pa && !ta;
			pr = pr && !tr;
		end
		if (pa || pr) give_up();
		@(negedge aclk);
	endtask : bus_read

	// A bounded wait for the loop state; running out of cycles ends the run as a failure.
	task automatic wait_active(input logic lvl, input int limit);
		int n;
		for (n = 0; n < limit && act !== lvl; n++) @(negedge aclk);
		if (act !== lvl) give_up();
	endtask : wait_active

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		bus_read(`LOOP_CTRL_ADDR);
		check_word(rd, 32'h00000000, "control reset value");
		check_bit(bpj, 1'b1, "backplane clock off attenuator");
		// Every error count source code must read back and reach the select lines.
		for (i = 0; i < 8; i++) begin
			bus_write(`LOOP_CTRL_ADDR, 32'(i));
			bus_read(`LOOP_CTRL_ADDR);
			check_word(rd, 32'(i), "control readback");
			check_word({29'h0, ecs}, 32'(i), "error count select");
		end
		bus_write(8'h40, 32'h000000FF);
		check_word({30'h0, rs}, 32'h00000002, "unmapped write response");
		bus_read(8'h40);
		check_word({30'h0, rs}, 32'h00000002, "unmapped read response");
		check_word(rd, 32'h00000000, "unmapped read data");
		// Each loop mode steers the fixed partner levels onto a distinct output pattern.
		for (i = 0; i < 5; i++) begin
			bus_write(`LOOP_CTRL_ADDR, {24'h0, route_ctrl[i]});
			repeat (4) @(negedge aclk);
			check_word({21'h0, jip, jin, lta, ltb, tpp, tpn, fra, frb, rop, ron, roc}, {21'h0, route_exp[i]},
				"loop routing");
			if (i != 2) check_bit(lta, 1'b1, "transmit runs on");
		end
		bus_write(`LOOP_PATTERN_ADDR, 32'h0000FFFF);
		bus_write(`LOOP_MASK_ADDR, 32'h00000004);
		bus_write(`LOOP_CTRL_ADDR, 32'h00000020);
		bus_read(`LOOP_STATUS_ADDR);
		// A loop-up burst broken off early must not count toward the entry time.
		@(posedge aclk);
		send_level <= 1'b1;
		send_en <= 1'b1;
		repeat (26) @(posedge aclk);
		send_level <= 1'b0;
		repeat (20) @(posedge aclk);
		send_level <= 1'b1;
		repeat (30) @(posedge aclk);
		@(negedge aclk);
		check_bit(act, 1'b0, "timer restarted after drop");
		check_bit(lus, 1'b1, "loop-up code seen");
		check_bit(irq, 1'b0, "masked events stay quiet");
		wait_active(1'b1, 20);
		repeat (3) @(negedge aclk);
		check_bit(ltb, 1'b1, "auto loop carries receive data");
		check_bit(irq, 1'b1, "loop entry interrupt");
		bus_read(`LOOP_STATUS_ADDR);
		check_word(rd, 32'h00000007, "latched events");
		check_bit(irq, 1'b0, "read clears status");
		// Loop-down must be held for the full interval before the loop is released.
		@(posedge aclk);
		send_level <= 1'b0;
		repeat (30) @(negedge aclk);
		check_bit(act, 1'b1, "still looped");
		check_bit(lds, 1'b1, "loop-down code seen");
		wait_active(1'b0, 20);
		repeat (3) @(negedge aclk);
		check_bit(ltb, 1'b0, "auto loop released");
		@(posedge aclk);
		send_level <= 1'b1;
		wait_active(1'b1, 60);
		bus_write(`LOOP_CTRL_ADDR, 32'h00000000);
		repeat (2) @(negedge aclk);
		check_bit(act, 1'b0, "enable drop resets auto state");
		wrap_up();
	end
endmodule : loop_ctrl_tb
